/* File: pao_capture_model.sv */
// Capture-side model: sampling clock source, stage decisions, word capture
// Assumes the bench hands in the decisions to apply to each new sample
`timescale 1ns/1ps
module pao_capture_model
(
  // Decisions from the bench
  input  wire pao_pkg::pao_dec_s          decIn,
  // Converter pins
  input  wire pao_pkg::pao_pins_s         pinsOut,
  input  wire pao_pkg::pao_pins_s         pinsOeN,
  output logic                            sampleClk,
  output pao_pkg::pao_dec_s               stageDec,
  // Captured results
  output logic [pao_pkg::WORD_W-1:0]      capWord,
  output logic                            capOor,
  output int                              capCount
);
  import pao_pkg::*;

  // Floating lines are pulled down
  wire logic [WORD_W-1:0] wordLvl = pinsOut.word & ~pinsOeN.word;
  wire logic oorLvl = pinsOut.outOfRange & ~pinsOeN.outOfRange;
  wire logic drLvl  = pinsOut.dataReadyOut & ~pinsOeN.dataReadyOut;

  initial
  begin
    sampleClk = 1'b0;
    stageDec  = '0;
    #7;
    forever
    begin
      #160;
      sampleClk = ~sampleClk;
      // Decisions settle mid-cycle, away from the sampling rise
      if (!sampleClk)
        stageDec = decIn;
    end
  end

  always @(negedge drLvl)
  begin
    #1;
    if (!pinsOeN.dataReadyOut)
    begin
      capWord  = wordLvl;
      capOor   = oorLvl;
      capCount = capCount + 1;
    end
  end
endmodule : pao_capture_model

/* File: pao_delay_line.sv */
// Shift-register delay line with registered output
// Assumes shift is a one-cycle pulse from the same clock
`timescale 1ns/1ps
module pao_delay_line
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = 1
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Data
  input  wire logic             shift,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  if (WIDTH < 1 || DEPTH < 1)
  begin : g_bad_param
    $error("pao_delay_line: WIDTH and DEPTH must be at least 1");
  end

  logic [DEPTH-1:0][WIDTH-1:0] taps_r;
  logic [DEPTH:0][WIDTH-1:0]   chain;

  // New value enters tap 0, the oldest one drops out
  assign chain = {taps_r, din};

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      taps_r <= '0;
    else if (shift)
      taps_r <= chain[DEPTH-1:0];
  end

  assign dout = taps_r[DEPTH-1];

endmodule : pao_delay_line

/* File: pao_output_interface.sv */
// Digital back end of a pipelined converter: alignment, correction, coding,
// out-of-range flag, data-ready strobe, tri-state control and APB registers
// Assumes sampling clock and control pins are asynchronous to mclk
//
// Operation
// RULE1: sample on clock rise, output on ready fall
// RULE2: nine stages, eight 1.5-bit, one comparator
// RULE3: align stage results, then remove redundancy
// RULE4: format low gives inverted MSB only
// RULE5: format high gives plain offset binary
// RULE6: enable low drives every output pin
// RULE7: enable high floats every output pin
// RULE8: conversion continues while outputs float
// RULE9: flag high when input beyond full scale
// RULE10: flag from all-zero or all-one word
// RULE11: data ready mirrors the sampling clock
// RULE12: clock source keeps 45 to 55 percent duty
// RULE13: partner keeps clock running, at least 0.5 Msps
// RULE14: fixed whole-cycle latency held as constant
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
module pao_output_interface
#(
  parameter int COUNT_W = 16
)
(
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // Converter pins and analog decisions
  input  wire logic                      sampleClk,
  input  wire logic                      outputFormatSelectN,
  input  wire logic                      outputEnableN,
  input  wire pao_pkg::pao_dec_s         stageDec,
  output pao_pkg::pao_pins_s             pinsOut,
  output pao_pkg::pao_pins_s             pinsOeN,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [pao_pkg::APB_AW-1:0] paddr,
  input  wire logic [pao_pkg::APB_DW-1:0] pwdata,
  output logic      [pao_pkg::APB_DW-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Interrupt
  output logic                           irq
);
  import pao_pkg::*;

  if (COUNT_W < 1 || COUNT_W > APB_DW)
  begin : g_bad_param
    $error("pao_output_interface: COUNT_W must lie in 1..32");
  end

  if (STAGES != RES_STAGES + 1 || LATENCY != RES_STAGES)
  begin : g_bad_shape
    $error("pao_output_interface: pipeline shape inconsistent");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ////////////////////////////////////////////////////////////////////////////

  logic [PIN_W-1:0] syncS1_r;
  logic [PIN_W-1:0] syncS2_r;
  logic [PIN_W-1:0] syncS3_r;
  logic [PIN_W-1:0] pinLvl_r;
  logic [PIN_W-1:0] pinLvl_nxt;
  logic [PIN_W-1:0] pinStable;
  pao_dec_s         decS1_r;
  pao_dec_s         decS2_r;
  pao_dec_s         decS3_r;
  logic             riseEv;
  logic             fallEv;
  logic             fmtLvl;
  logic             oeNLvl;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      syncS1_r <= PIN_LVL_RST;
      syncS2_r <= PIN_LVL_RST;
      syncS3_r <= PIN_LVL_RST;
      pinLvl_r <= PIN_LVL_RST;
    end
    else
    begin
      syncS1_r <= {outputFormatSelectN, outputEnableN, sampleClk};
      syncS2_r <= syncS1_r;
      syncS3_r <= syncS2_r;
      pinLvl_r <= pinLvl_nxt;
    end
  end

  // Decisions settle before the synchronised clock edge is seen
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      decS1_r <= '0;
      decS2_r <= '0;
      decS3_r <= '0;
    end
    else
    begin
      decS1_r <= stageDec;
      decS2_r <= decS1_r;
      decS3_r <= decS2_r;
    end
  end

  // A level counts once the second and third stages agree
  assign pinStable  = ~(syncS2_r ^ syncS3_r);
  assign pinLvl_nxt = (syncS3_r & pinStable) | (pinLvl_r & ~pinStable);
  assign riseEv     = pinLvl_nxt[PIN_CLK] & ~pinLvl_r[PIN_CLK]; // RULE1
  assign fallEv     = ~pinLvl_nxt[PIN_CLK] & pinLvl_r[PIN_CLK]; // RULE1
  assign fmtLvl     = pinLvl_r[PIN_FMT];
  assign oeNLvl     = pinLvl_r[PIN_OE];

  ////////////////////////////////////////////////////////////////////////////
  // Stage alignment and correction
  ////////////////////////////////////////////////////////////////////////////

  wire logic [RES_STAGES-1:0][CODE_W-1:0] alignedCode;
  wire logic                              alignedLast;
  pao_dec_s                               aligned;
  logic [WORD_W-1:0]                      corrWord;
  logic                                   corrOor;

  // Stage i decides sample n-i at rise n; delay STAGES-i lines them up
  for (genvar i = 0; i < RES_STAGES; i++)
  begin : g_align
    pao_delay_line #(
      .WIDTH (CODE_W),
      .DEPTH (STAGES - i)
    ) u_stage (
      .mclk  (mclk),
      .rst   (rst),
      .shift (riseEv),
      .din   (decS3_r.code[i]),
      .dout  (alignedCode[i])
    ); // RULE2 RULE3
  end

  pao_delay_line #(
    .WIDTH (1),
    .DEPTH (STAGES - RES_STAGES)
  ) u_last (
    .mclk  (mclk),
    .rst   (rst),
    .shift (riseEv),
    .din   (decS3_r.last),
    .dout  (alignedLast)
  ); // RULE2 RULE3

  assign aligned.code = alignedCode;
  assign aligned.last = alignedLast;
  assign corrWord     = pao_correct(aligned); // RULE3
  assign corrOor      = pao_is_oor(corrWord); // RULE10

  ////////////////////////////////////////////////////////////////////////////
  // Output register and pin drive
  ////////////////////////////////////////////////////////////////////////////

  logic [WORD_W-1:0]  dataWord_r;
  logic [WORD_W-1:0]  dataWord_nxt;
  logic               oor_r;
  logic [COUNT_W-1:0] sampleCnt_r;

  // Only the MSB differs between the two codings
  assign dataWord_nxt = {corrWord[WORD_W-1] ^ ~fmtLvl,
                         corrWord[WORD_W-2:0]}; // RULE4 RULE5

  // Words leave on the ready fall, whatever the enable, so they stay current
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dataWord_r <= '0;
      oor_r      <= 1'b0;
    end
    else if (fallEv)
    begin
      dataWord_r <= dataWord_nxt; // RULE1 RULE14
      oor_r      <= corrOor;      // RULE9
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sampleCnt_r <= '0;
    else if (riseEv)
      sampleCnt_r <= sampleCnt_r + 1'b1; // RULE8
  end

  assign pinsOut.word         = dataWord_r;
  assign pinsOut.outOfRange   = oor_r;
  assign pinsOut.dataReadyOut = pinLvl_r[PIN_CLK]; // RULE11
  assign pinsOeN = {($bits(pao_pins_s)){oeNLvl}}; // RULE6 RULE7

  ////////////////////////////////////////////////////////////////////////////
  // APB registers and interrupt
  ////////////////////////////////////////////////////////////////////////////

  logic [EV_W-1:0]   status_r;
  logic [EV_W-1:0]   status_nxt;
  logic [EV_W-1:0]   mask_r;
  logic [EV_W-1:0]   evSet;
  logic [EV_W-1:0]   w1c;
  logic [APB_DW-1:0] rdMux;
  logic [APB_DW-1:0] prdata_r;
  logic              accessPh;
  logic              wrEn;
  logic              selStatus;
  logic              selMask;
  logic              selData;
  logic              selCount;
  logic              mapped;

  assign accessPh  = psel & penable;
  assign wrEn      = accessPh & pwrite & mapped;
  assign selStatus = paddr == REG_STATUS;
  assign selMask   = paddr == REG_MASK;
  assign selData   = paddr == REG_DATA;
  assign selCount  = paddr == REG_COUNT;
  assign mapped    = selStatus | selMask | selData | selCount;

  assign evSet[EV_OOR]  = fallEv & corrOor;
  assign evSet[EV_WORD] = fallEv;
  assign w1c        = (wrEn & selStatus) ? pwdata[EV_W-1:0] : '0;
  // Set wins over a clear in the same cycle
  assign status_nxt = (status_r & ~w1c) | evSet;

  assign rdMux =
    selStatus ? {{(APB_DW-EV_W){1'b0}}, status_r} :
    selMask   ? {{(APB_DW-EV_W){1'b0}}, mask_r} :
    selData   ? {{(APB_DW-DATA_OE_BIT-1){1'b0}}, oeNLvl, fmtLvl, oor_r,
                 dataWord_r} :
    selCount  ? {{(APB_DW-COUNT_W){1'b0}}, sampleCnt_r} :
                '0;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      status_r <= EV_RST;
      mask_r   <= MASK_RST;
      prdata_r <= '0;
    end
    else
    begin
      status_r <= status_nxt;
      if (wrEn && selMask)
        mask_r <= pwdata[EV_W-1:0];
      if (psel && !penable)
        prdata_r <= rdMux;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = accessPh & ~mapped;
  assign irq     = |(status_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////

  AST_DR_RISE: assert property (@(posedge mclk) disable iff (rst) // RULE11
    riseEv |=> pinsOut.dataReadyOut)
    else $error("data ready did not follow sampling clock rise");

  AST_WORD_ON_FALL: assert property (@(posedge mclk) disable iff (rst) // RULE1
    $fell(pinsOut.dataReadyOut) |->
      pinsOut.word[WORD_W-2:0] == $past(corrWord[WORD_W-2:0]))
    else $error("word not updated at data ready fall");

  AST_WORD_HOLD: assert property (@(posedge mclk) disable iff (rst) // RULE1
    !$fell(pinsOut.dataReadyOut) |-> $stable(pinsOut.word))
    else $error("word changed away from data ready fall");

  AST_TWOS_MSB: assert property (@(posedge mclk) disable iff (rst) // RULE4
    ($fell(pinsOut.dataReadyOut) && !$past(fmtLvl)) |->
      pinsOut.word[WORD_W-1] == !$past(corrWord[WORD_W-1]))
    else $error("msb not inverted in twos complement mode");

  AST_BIN_MSB: assert property (@(posedge mclk) disable iff (rst) // RULE5
    ($fell(pinsOut.dataReadyOut) && $past(fmtLvl)) |->
      pinsOut.word[WORD_W-1] == $past(corrWord[WORD_W-1]))
    else $error("msb altered in binary mode");

  AST_DRIVE: assert property (@(posedge mclk) disable iff (rst) // RULE6
    !outputEnableN [*4] |=> pinsOeN == '0)
    else $error("outputs not driven while enabled");

  AST_HIZ: assert property (@(posedge mclk) disable iff (rst) // RULE7
    outputEnableN [*4] |=> pinsOeN == '1)
    else $error("outputs driven while disabled");

  AST_OOR_FLAG: assert property (@(posedge mclk) // RULE9 RULE10
    disable iff (rst) $fell(pinsOut.dataReadyOut) |->
      pinsOut.outOfRange == pao_is_oor($past(corrWord)))
    else $error("out of range flag does not match word");

  AST_CONV_HIZ: assert property (@(posedge mclk) disable iff (rst) // RULE8
    (riseEv && oeNLvl) |=> sampleCnt_r == $past(sampleCnt_r) + 1'b1)
    else $error("conversion stalled while outputs float");

  AST_LAST_ALIGN: assert property (@(posedge mclk) disable iff (rst) // RULE3
    riseEv |=> alignedLast == $past(decS3_r.last))
    else $error("comparator stage not aligned");

  AST_DR_FALL: assert property (@(posedge mclk) disable iff (rst) // RULE11
    fallEv |=> !pinsOut.dataReadyOut)
    else $error("data ready did not follow sampling clock fall");

  AST_DR_STABLE: assert property (@(posedge mclk) disable iff (rst) // RULE11
    !(riseEv || fallEv) |=> $stable(pinsOut.dataReadyOut))
    else $error("data ready moved without a sampling clock edge");

  AST_OOR_HOLD: assert property (@(posedge mclk) disable iff (rst) // RULE9
    !$fell(pinsOut.dataReadyOut) |-> $stable(pinsOut.outOfRange))
    else $error("out of range flag changed away from data ready fall");

  AST_OOR_SAT: assert property (@(posedge mclk) disable iff (rst) // RULE10
    ($fell(pinsOut.dataReadyOut) && pinsOut.outOfRange) |->
      ($past(corrWord) == '0 || $past(corrWord) == '1))
    else $error("out of range flag without a saturated word");

  AST_OOR_EVENT: assert property (@(posedge mclk) disable iff (rst) // RULE9
    ($fell(pinsOut.dataReadyOut) && pinsOut.outOfRange) |->
      status_r[EV_OOR])
    else $error("out of range event not recorded");

  AST_WORD_EVENT: assert property (@(posedge mclk) disable iff (rst) // RULE1
    $fell(pinsOut.dataReadyOut) |-> status_r[EV_WORD])
    else $error("new word event not recorded");

  AST_CNT_HOLD: assert property (@(posedge mclk) disable iff (rst) // RULE8
    !riseEv |=> $stable(sampleCnt_r))
    else $error("sample count moved without a sampling clock rise");

endmodule : pao_output_interface

/* File: pao_pkg.sv */
// Shared constants, types and decode functions for the converter output block
// Assumes a single mclk domain; the pins are synchronised by the user module
package pao_pkg;

  // Pipeline shape
  localparam int STAGES      = 9;
  localparam int RES_STAGES  = 8;
  localparam int CODE_W      = 2;
  localparam int WORD_W      = 10;
  localparam int LATENCY     = STAGES - 1;
  localparam int SYNC_STAGES = 3;

  // APB map
  localparam int         APB_AW     = 8;
  localparam int         APB_DW     = 32;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_COUNT  = 8'h0C;

  // Event bits, same layout in status and mask
  localparam int         EV_W     = 2;
  localparam int         EV_OOR   = 0;
  localparam int         EV_WORD  = 1;
  localparam logic [1:0] EV_RST   = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // Data register fields above the word
  localparam int DATA_OOR_BIT = 10;
  localparam int DATA_FMT_BIT = 11;
  localparam int DATA_OE_BIT  = 12;

  // Synchronised pin levels
  localparam int         PIN_W       = 3;
  localparam int         PIN_CLK     = 0;
  localparam int         PIN_OE      = 1;
  localparam int         PIN_FMT     = 2;
  localparam logic [2:0] PIN_LVL_RST = 3'h6;

  // Raw stage decisions from the analog pipeline
  typedef struct packed {
    logic [RES_STAGES-1:0][CODE_W-1:0] code;
    logic                              last;
  } pao_dec_s;

  // Output pin group
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic              outOfRange;
    logic              dataReadyOut;
  } pao_pins_s;

  // Redundancy removal: weighted sum of overlapping stage codes
  function automatic logic [WORD_W-1:0] pao_correct(input pao_dec_s d);
    logic [WORD_W:0] acc;
    acc = {{WORD_W{1'b0}}, d.last};
    for (int i = 0; i < RES_STAGES; i++)
    begin
      acc = acc + ({{(WORD_W-1){1'b0}}, d.code[i]} << (RES_STAGES - i));
    end
    return acc[WORD_W-1:0];
  endfunction : pao_correct

  // Saturated word: all zeros or all ones
  function automatic logic pao_is_oor(input logic [WORD_W-1:0] w);
    return (&w) | ~(|w);
  endfunction : pao_is_oor

endpackage : pao_pkg

/* File: test_pipelined_adc_output_interface.sv */
// Self-checking bench for the converter output block
// Assumes pao_pkg, the design and the capture model are compiled first
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samplesChecked++; \
    if ((got) !== (exp)) \
    begin \
      badCount++; \
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module test_pipelined_adc_output_interface;
  import pao_pkg::*;
  localparam logic [16:0] DEC_B  = 17'h12493;
  localparam logic [9:0]  WORD_B = 10'h249;
  logic              mclk;
  logic              rst;
  logic              fmtN;
  logic              oeN;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata;
  logic [APB_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              sampleClk;
  pao_dec_s          stageDec;
  pao_dec_s          decIn;
  pao_pins_s         pinsOut;
  pao_pins_s         pinsOeN;
  logic [WORD_W-1:0] capWord;
  logic              capOor;
  int                capCount;
  int                badCount;
  int                samplesChecked;
  int                cycles;
  int                k0;
  logic [APB_DW-1:0] rd;
  logic [APB_DW-1:0] c0;
  logic              err;

  pao_output_interface dut_u (.mclk(mclk), .rst(rst), .sampleClk(sampleClk),
    .outputFormatSelectN(fmtN), .outputEnableN(oeN), .stageDec(stageDec),
    .pinsOut(pinsOut), .pinsOeN(pinsOeN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));

  pao_capture_model cap_u (.decIn(decIn), .pinsOut(pinsOut),
    .pinsOeN(pinsOeN), .sampleClk(sampleClk), .stageDec(stageDec),
    .capWord(capWord), .capOor(capOor), .capCount(capCount));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic closeOut;
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : closeOut

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      badCount++;
      closeOut();
    end
  end

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  ////////////////////////////////////////////////////////////////////////////
  task automatic testReset;
    `CHK(pinsOeN, 12'hFFF)
    apb(1'b0, REG_MASK, 32'h0);
    `CHK(rd[1:0], MASK_RST)
    `CHK(pready, 1'b1)
    `CHK(irq, 1'b0)
    apb(1'b1, 8'h10, 32'h3);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test reset done");
  endtask : testReset

  task automatic testOor;
    @(posedge mclk);
    oeN <= 1'b0;
    repeat (12) @(capCount);
    `CHK(pinsOeN, 12'h000)
    `CHK(capWord, 10'h000)
    `CHK(capOor, 1'b1)
    apb(1'b0, REG_DATA, 32'h0);
    `CHK(rd[DATA_OOR_BIT], 1'b1)
    $display("test range done");
  endtask : testOor

  task automatic testLatency;
    @(capCount);
    decIn = DEC_B;
    repeat (9) @(capCount);
    `CHK(capWord !== WORD_B, 1'b1)
    @(capCount);
    `CHK(capWord, WORD_B)
    `CHK(capWord, WORD_B)
    `CHK(capWord, WORD_B)
    `CHK(capOor, 1'b0)
    $display("test latency done");
  endtask : testLatency

  task automatic testFormat;
    @(posedge mclk);
    fmtN <= 1'b0;
    repeat (3) @(capCount);
    `CHK(capWord, WORD_B ^ 10'h200)
    `CHK(capOor, 1'b0)
    @(posedge mclk);
    fmtN <= 1'b1;
    repeat (3) @(capCount);
    `CHK(capWord, WORD_B)
    $display("test format done");
  endtask : testFormat

  task automatic testFloat;
    @(posedge mclk);
    oeN <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK(pinsOeN, 12'hFFF)
    k0 = capCount;
    apb(1'b0, REG_COUNT, 32'h0);
    c0 = rd;
    repeat (80) @(posedge mclk);
    apb(1'b0, REG_COUNT, 32'h0);
    `CHK((rd - c0) inside {[9:11]}, 1'b1)
    `CHK(capCount == k0, 1'b1)
    @(posedge mclk);
    oeN <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK(pinsOeN, 12'h000)
    @(capCount);
    `CHK(capWord, WORD_B)
    k0 = capCount;
    repeat (80) @(posedge mclk);
    `CHK((capCount - k0) inside {[9:11]}, 1'b1)
    $display("test float done");
  endtask : testFloat

  task automatic testIrq;
    apb(1'b1, REG_STATUS, 32'h3);
    apb(1'b1, REG_MASK, 32'h0);
    repeat (2) @(capCount);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[1:0], 2'h2)
    `CHK(irq, 1'b0)
    apb(1'b1, REG_MASK, 32'h2);
    apb(1'b0, REG_MASK, 32'h0);
    `CHK(rd[1:0], 2'h2)
    `CHK(irq, 1'b1)
    apb(1'b1, REG_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    $display("test interrupt done");
  endtask : testIrq

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    fmtN = 1'b1;
    oeN = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    decIn = '0;
    badCount = 0;
    samplesChecked = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    testReset();
    testOor();
    testLatency();
    testFormat();
    testFloat();
    testIrq();
    closeOut();
  end
endmodule : test_pipelined_adc_output_interface
